// [pkg/pbh_params.svh]
// Constants for the primary bus hold hand-over block.
`ifndef PBH_PARAMS_SVH
`define PBH_PARAMS_SVH
`define PBH_ADDR_W 24
`define PBH_DATA_W 32
`define PBH_WS_W 3
`define PBH_SYNC_RESET 1'b0
`define PBH_STROBE_IDLE 1'b1
`define PBH_RW_READ 1'b1
`endif

// [pkg/pbh_pkg.sv]
// Types shared by the primary bus hold hand-over block.
package pbh_pkg;
  typedef enum logic [1:0] {
    PBH_IDLE,
    PBH_ACCESS,
    PBH_HOLD,
    PBH_RELEASE
  } pbh_state_t;
endpackage : pbh_pkg

// [src/pbh_sync2.sv]
// Two-flop synchroniser for inputs arriving from outside the clock domain.
`timescale 1ns/10ps
`default_nettype none
`include "pbh_params.svh"
module pbh_sync2 #(
  parameter int W = 1
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_clk_en,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;

  // The first stage feeds only the second stage.
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      meta_reg <= {W{`PBH_SYNC_RESET}};
      sync_reg <= {W{`PBH_SYNC_RESET}};
    end else if (i_clk_en) begin
      meta_reg <= i_async;
      sync_reg <= meta_reg;
    end
  end

  assign o_sync = sync_reg;
endmodule : pbh_sync2
`default_nettype wire

// [src/pbh_hold_ctrl.sv]
// Primary bus controller with hold request and hold grant hand-over.
//
// Overview of operation
// - Hold request synchronised; may slip one cycle.
// - Override bit exits hold, blocks new holds.
// - No bus access in hold; reads stall.
// - One write posted in hold; second stalls.
// - Hold sampled before cycle end; width waits+1.
// - Grant stays low one cycle after release.
// - Bus outputs released while hold granted.
`timescale 1ns/10ps
`default_nettype none
`include "pbh_params.svh"
module pbh_hold_ctrl #(
  parameter int ADDR_W = `PBH_ADDR_W,
  parameter int DATA_W = `PBH_DATA_W,
  parameter int WS_W = `PBH_WS_W
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_clk_en,
  input wire logic i_hold_req_n,
  input wire logic i_hold_override,
  input wire logic [WS_W-1:0] i_wait_state_count,
  input wire logic i_core_valid,
  input wire logic i_core_write,
  input wire logic [ADDR_W-1:0] i_core_addr,
  input wire logic [DATA_W-1:0] i_core_wdata,
  output logic o_core_ready,
  output logic o_core_stall,
  output logic o_access_done,
  output logic o_rdata_valid,
  output logic [DATA_W-1:0] o_rdata,
  output logic o_bus_hold_grant_n,
  output logic o_primary_bus_strobe_n,
  output logic o_primary_bus_strobe_oe,
  output logic o_rw,
  output logic o_rw_oe,
  output logic [ADDR_W-1:0] o_addr,
  output logic o_addr_oe,
  output logic [DATA_W-1:0] o_data,
  output logic o_data_oe,
  input wire logic [DATA_W-1:0] i_data
);
  pbh_pkg::pbh_state_t state_reg;
  logic hold_act;
  logic [DATA_W-1:0] data_s;
  logic hold_want;
  logic in_hold;
  logic take;
  logic last;
  logic [WS_W-1:0] cnt_reg;
  logic pend_reg;
  logic [ADDR_W-1:0] pend_addr_reg;
  logic [DATA_W-1:0] pend_data_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic [DATA_W-1:0] wdata_reg;
  logic wr_reg;
  logic done_reg;
  logic rvalid_reg;
  logic [DATA_W-1:0] rdata_reg;

  // The hold pin may move anywhere in the cycle, so it is resynchronised
  // and recognition can land one cycle later than the ideal sequence.
  pbh_sync2 #(.W(1)) u_hold_sync (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_clk_en(i_clk_en),
    .i_async(~i_hold_req_n),
    .o_sync(hold_act)
  );

  pbh_sync2 #(.W(DATA_W)) u_data_sync (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_clk_en(i_clk_en),
    .i_async(i_data),
    .o_sync(data_s)
  );

  assign hold_want = hold_act && !i_hold_override;
  assign in_hold = (state_reg == pbh_pkg::PBH_HOLD) || (state_reg == pbh_pkg::PBH_RELEASE);
  assign last = (state_reg == pbh_pkg::PBH_ACCESS) && (cnt_reg == '0);

  // Reads always wait out a hold; a single write may be parked meanwhile.
  always_comb begin
    case (state_reg)
      pbh_pkg::PBH_IDLE: o_core_ready = !hold_want && !pend_reg;
      pbh_pkg::PBH_HOLD,
      pbh_pkg::PBH_RELEASE: o_core_ready = i_core_write && !pend_reg;
      default: o_core_ready = 1'b0;
    endcase
  end

  assign o_core_stall = i_core_valid && !o_core_ready;
  assign take = i_clk_en && i_core_valid && o_core_ready;

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      state_reg <= pbh_pkg::PBH_IDLE;
    end else if (i_clk_en) begin
      case (state_reg)
        pbh_pkg::PBH_IDLE: begin
          if (hold_want) begin
            state_reg <= pbh_pkg::PBH_HOLD;
          end else if (pend_reg || take) begin
            state_reg <= pbh_pkg::PBH_ACCESS;
          end
        end
        pbh_pkg::PBH_ACCESS: begin
          // The request is judged in the last cycle, so the grant follows
          // the completed cycle with all its wait states.
          if (last) begin
            state_reg <= hold_want ? pbh_pkg::PBH_HOLD : pbh_pkg::PBH_IDLE;
          end
        end
        pbh_pkg::PBH_HOLD: begin
          if (i_hold_override) begin
            state_reg <= pbh_pkg::PBH_IDLE;
          end else if (!hold_act) begin
            state_reg <= pbh_pkg::PBH_RELEASE;
          end
        end
        default: begin
          state_reg <= pbh_pkg::PBH_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      cnt_reg <= '0;
      addr_reg <= '0;
      wdata_reg <= '0;
      wr_reg <= 1'b0;
    end else if (i_clk_en) begin
      if (state_reg == pbh_pkg::PBH_IDLE && !hold_want && pend_reg) begin
        cnt_reg <= i_wait_state_count;
        addr_reg <= pend_addr_reg;
        wdata_reg <= pend_data_reg;
        wr_reg <= 1'b1;
      end else if (state_reg == pbh_pkg::PBH_IDLE && take) begin
        cnt_reg <= i_wait_state_count;
        addr_reg <= i_core_addr;
        wdata_reg <= i_core_wdata;
        wr_reg <= i_core_write;
      end else if (state_reg == pbh_pkg::PBH_ACCESS && !last) begin
        cnt_reg <= cnt_reg - 1'b1;
      end
    end
  end

  // Set only in hold and cleared only from idle, so the two never collide.
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      pend_reg <= 1'b0;
      pend_addr_reg <= '0;
      pend_data_reg <= '0;
    end else if (i_clk_en) begin
      if (in_hold && take) begin
        pend_reg <= 1'b1;
        pend_addr_reg <= i_core_addr;
        pend_data_reg <= i_core_wdata;
      end else if (state_reg == pbh_pkg::PBH_IDLE && !hold_want) begin
        pend_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      done_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
    end else if (i_clk_en) begin
      done_reg <= last;
      rvalid_reg <= last && !wr_reg;
      if (last && !wr_reg) begin
        rdata_reg <= data_s;
      end
    end
  end

  assign o_access_done = done_reg;
  assign o_rdata_valid = rvalid_reg;
  assign o_rdata = rdata_reg;
  assign o_bus_hold_grant_n = !in_hold;
  assign o_primary_bus_strobe_n = (state_reg == pbh_pkg::PBH_ACCESS) ? 1'b0 : `PBH_STROBE_IDLE;
  assign o_rw = wr_reg ? 1'b0 : `PBH_RW_READ;
  assign o_addr = addr_reg;
  assign o_data = wdata_reg;
  // Everything the bus master might drive is let go for the whole grant.
  assign o_primary_bus_strobe_oe = !in_hold;
  assign o_rw_oe = !in_hold;
  assign o_addr_oe = !in_hold;
  assign o_data_oe = (state_reg == pbh_pkg::PBH_ACCESS) && wr_reg;

  sequence s_quiet_release;
    !hold_act && !i_hold_override && i_clk_en;
  endsequence

  sequence s_grant_tail;
    !o_bus_hold_grant_n && state_reg == pbh_pkg::PBH_RELEASE;
  endsequence

  property p_sync;
    @(posedge i_clock) disable iff (i_rst)
      $past(i_clk_en, 1) && $past(i_clk_en, 2) |-> hold_act == !$past(i_hold_req_n, 2);
  endproperty
  a_sync: assert property (p_sync) else $error("hold sync latency wrong");

  property p_override;
    @(posedge i_clock) disable iff (i_rst)
      i_hold_override && i_clk_en |=> o_bus_hold_grant_n;
  endproperty
  a_override: assert property (p_override) else $error("hold kept under override");

  property p_read_stall;
    @(posedge i_clock) disable iff (i_rst)
      in_hold && i_core_valid && !i_core_write |-> o_core_stall && o_primary_bus_strobe_n;
  endproperty
  a_read_stall: assert property (p_read_stall) else $error("read ran during hold");

  property p_post;
    @(posedge i_clock) disable iff (i_rst)
      in_hold && i_core_valid && i_core_write |-> o_core_stall == pend_reg;
  endproperty
  a_post: assert property (p_post) else $error("posted write slot wrong");

  property p_sample;
    @(posedge i_clock) disable iff (i_rst)
      last && hold_want && i_clk_en |=> state_reg == pbh_pkg::PBH_HOLD && !o_bus_hold_grant_n;
  endproperty
  a_sample: assert property (p_sample) else $error("hold missed at cycle end");

  property p_release;
    @(posedge i_clock) disable iff (i_rst)
      (state_reg == pbh_pkg::PBH_HOLD) ##0 s_quiet_release |=> s_grant_tail;
  endproperty
  a_release: assert property (p_release) else $error("grant dropped too early");

  property p_float;
    @(posedge i_clock) disable iff (i_rst)
      !o_bus_hold_grant_n |-> !o_primary_bus_strobe_oe && !o_rw_oe && !o_addr_oe && !o_data_oe;
  endproperty
  a_float: assert property (p_float) else $error("bus driven during hold");

  property p_finish;
    @(posedge i_clock) disable iff (i_rst)
      state_reg == pbh_pkg::PBH_ACCESS && cnt_reg != '0 && i_clk_en
        |=> state_reg == pbh_pkg::PBH_ACCESS && o_bus_hold_grant_n;
  endproperty
  a_finish: assert property (p_finish) else $error("grant cut a bus cycle");
endmodule : pbh_hold_ctrl
`default_nettype wire

// [dv/pbh_ext_master.sv]
// External bus master model that requests the primary bus through the hold pin.
`timescale 1ns/10ps
`default_nettype none
module pbh_ext_master (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_go,
  input wire logic [4:0] i_width,
  input wire logic i_bus_hold_grant_n,
  output logic o_hold_req_n
);
  logic [4:0] cnt_reg;
  logic [1:0] seen_reg;
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_hold_req_n <= 1'b1;
      cnt_reg <= 5'h00;
      seen_reg <= 2'h0;
    end else if (o_hold_req_n) begin
      o_hold_req_n <= !i_go;
      cnt_reg <= 5'h00;
      seen_reg <= 2'h0;
    end else begin
      // Releasing early would let the device miss the request, so both limits must pass.
      if (cnt_reg < i_width) cnt_reg <= cnt_reg + 5'h01;
      if (!i_bus_hold_grant_n && seen_reg != 2'h2) seen_reg <= seen_reg + 2'h1;
      if (cnt_reg >= i_width && seen_reg == 2'h2) o_hold_req_n <= 1'b1;
    end
  end
endmodule : pbh_ext_master
`default_nettype wire

// [dv/tb.sv]
// Self-checking bench for the primary bus hold hand-over controller.
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic clk = 1'b0, rst = 1'b1, ovr = 1'b0, valid = 1'b0, wr = 1'b0, go = 1'b0;
  logic [2:0] ws = 3'h0;
  logic [4:0] width = 5'h03;
  logic [23:0] addr = 24'h000000, addr_o;
  logic [31:0] wdata = 32'h00000000, din = 32'h5a5a0f0f, dout, rdata;
  logic req_n, ready, stall, done, rdv, grant_n, primary_bus_strobe_n, primary_bus_strobe_oe, rw, rw_oe, addr_oe, data_oe;
  int miscompares = 0, n_compared = 0, cycles = 0;
  always #5 clk = ~clk;
  pbh_hold_ctrl pbh_hold_ctrl_inst (.i_clock(clk), .i_rst(rst), .i_clk_en(1'b1),
    .i_hold_req_n(req_n), .i_hold_override(ovr), .i_wait_state_count(ws), .i_core_valid(valid),
    .i_core_write(wr), .i_core_addr(addr), .i_core_wdata(wdata), .o_core_ready(ready),
    .o_core_stall(stall), .o_access_done(done), .o_rdata_valid(rdv), .o_rdata(rdata),
    .o_bus_hold_grant_n(grant_n), .o_primary_bus_strobe_n(primary_bus_strobe_n),
    .o_primary_bus_strobe_oe(primary_bus_strobe_oe), .o_rw(rw), .o_rw_oe(rw_oe), .o_addr(addr_o),
    .o_addr_oe(addr_oe), .o_data(dout), .o_data_oe(data_oe), .i_data(din));
  pbh_ext_master pbh_ext_master_inst (.i_clock(clk), .i_rst(rst), .i_go(go), .i_width(width),
    .i_bus_hold_grant_n(grant_n), .o_hold_req_n(req_n));
  task automatic conclude;
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : conclude
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      miscompares++;
      conclude();
    end
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic until_grant(input logic lvl, output int n);
    n = 0;
    while (grant_n !== lvl && n < 40) begin
      @(negedge clk);
      n++;
    end
  endtask : until_grant
  // Starts a hold request; returns at the negedge of the first cycle with the pin low.
  task automatic request(input logic [4:0] w);
    @(posedge clk);
    width <= w;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    @(negedge clk);
  endtask : request
  task automatic finish_hold(output int m);
    int k;
    k = 0;
    while (req_n !== 1'b1 && k < 60) begin
      @(negedge clk);
      k++;
    end
    until_grant(1'b1, m);
  endtask : finish_hold
  // Returns the number of cycles the request was refused with stall shown.
  task automatic access(input logic w, input logic [23:0] a, input logic [31:0] d,
                        output int n);
    int k;
    @(posedge clk);
    valid <= 1'b1;
    wr <= w;
    addr <= a;
    wdata <= d;
    n = 0;
    k = 0;
    @(negedge clk);
    while (ready !== 1'b1 && k < 40) begin
      n += int'(stall === 1'b1);
      k++;
      @(negedge clk);
    end
    @(posedge clk);
    valid <= 1'b0;
    @(negedge clk);
  endtask : access
  task automatic t_read;
    int n, lo, at, rv;
    @(posedge clk);
    ws <= 3'h2;
    access(1'b0, 24'h000100, 32'h00000000, n);
    chk("read direction", 1, rw);
    chk("read address", 24'h000100, addr_o);
    lo = 0;
    at = 0;
    rv = 0;
    for (int k = 1; k <= 6; k++) begin
      lo += int'(primary_bus_strobe_n === 1'b0);
      if (done === 1'b1) at = k;
      if (rdv === 1'b1) rv = k;
      @(negedge clk);
    end
    chk("read valid position", 4, rv);
    chk("strobe low cycles", 3, lo);
    chk("done position", 4, at);
    chk("read data", din, rdata);
    $display("test read done");
  endtask : t_read
  task automatic t_hold_idle;
    int n;
    request(5'h03);
    until_grant(1'b0, n);
    chk("grant delay", 3, n);
    chk("outputs released", 0, {primary_bus_strobe_oe, rw_oe, addr_oe, data_oe});
    finish_hold(n);
    chk("grant tail", 4, n);
    chk("outputs driven", 7, {primary_bus_strobe_oe, rw_oe, addr_oe});
    $display("test hold from idle done");
  endtask : t_hold_idle
  task automatic t_hold_access;
    int n, k;
    logic early;
    @(posedge clk);
    ws <= 3'h5;
    access(1'b1, 24'h000200, 32'hcafe0123, n);
    chk("write direction", 0, rw);
    chk("write address", 24'h000200, addr_o);
    chk("write data", 32'hcafe0123, dout);
    chk("write data enable", 1, data_oe);
    request(5'h08);
    early = 1'b0;
    k = 0;
    while (done !== 1'b1 && k < 12) begin
      early |= (grant_n !== 1'b1);
      k++;
      @(negedge clk);
    end
    chk("grant before cycle end", 0, early);
    until_grant(1'b0, n);
    chk("grant with cycle end", 0, n);
    chk("grant after cycle", 0, grant_n);
    finish_hold(n);
    $display("test hold during access done");
  endtask : t_hold_access
  task automatic t_posted;
    int n;
    request(5'h08);
    until_grant(1'b0, n);
    access(1'b1, 24'h000300, 32'h11112222, n);
    chk("posted write stall", 0, n);
    chk("strobe in hold", 1, primary_bus_strobe_n);
    access(1'b1, 24'h000304, 32'h33334444, n);
    chk("second write waits", 1, 32'(n > 0));
    chk("grant at second take", 1, grant_n);
    chk("second write address", 24'h000304, addr_o);
    chk("second write data", 32'h33334444, dout);
    finish_hold(n);
    $display("test posted write done");
  endtask : t_posted
  task automatic t_override;
    int n;
    logic low;
    request(5'h1f);
    until_grant(1'b0, n);
    @(posedge clk);
    ovr <= 1'b1;
    @(negedge clk);
    @(negedge clk);
    chk("grant after override", 1, grant_n);
    low = 1'b0;
    repeat (10) begin
      low |= (grant_n !== 1'b1);
      @(negedge clk);
    end
    chk("grant while overridden", 0, low);
    access(1'b0, 24'h000400, 32'h00000000, n);
    chk("read while overridden", 0, n);
    finish_hold(n);
    @(posedge clk);
    ovr <= 1'b0;
    $display("test override done");
  endtask : t_override
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    t_read();
    t_hold_idle();
    t_hold_access();
    t_posted();
    t_override();
    conclude();
  end
endmodule : tb
`default_nettype wire
